// ===== ifvm_pkg.sv
// Purpose: Shared constants and types for the interrupt flag and vector map block.
// Assumes: AXI4-Lite register access, one 20 MHz clock, synchronous active-low reset.
// Notes: Contract
package ifvm_pkg;

    localparam int unsigned N_SRC = 15;
    localparam int unsigned ADDR_W = 18;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_LOW = 16'hFE04;
    localparam logic [15:0] IDX_MID = 16'hFE05;
    localparam logic [15:0] IDX_HIGH = 16'hFE06;
    localparam logic [15:0] IDX_EVENT = 16'hFE10;
    localparam logic [15:0] IDX_MASK = 16'hFE11;
    localparam logic [15:0] IDX_VECTOR = 16'hFE12;
    localparam logic [ADDR_W-1:0] A_LOW = {IDX_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] A_MID = {IDX_MID, 2'b00};
    localparam logic [ADDR_W-1:0] A_HIGH = {IDX_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] A_EVENT = {IDX_EVENT, 2'b00};
    localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] A_VECTOR = {IDX_VECTOR, 2'b00};

    // Reset values and bus answers
    localparam logic [15:1] MASK_RST = 15'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Vector table: entry 0 is the software interrupt, entry n is source n
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0][15:0] VEC_TAB = {
        16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC,
        16'hFFEE, 16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC
    };

    typedef logic [N_SRC:1] ifvm_src_t;

    // Vector offered to the core
    typedef struct packed {
        logic valid;
        logic rst;
        logic [3:0] src;
        logic [15:0] addr;
    } ifvm_vec_t;

endpackage

// ===== ifvm_prio_enc.sv
// Purpose: Fixed-priority pick of the pending entry with the lowest index.
// Assumes: Entry 0 is the software interrupt, entries 1..15 the sources.
// Notes: Lowest index means highest vector address, hence highest priority.
`timescale 1ns/10ps
`default_nettype none
module ifvm_prio_enc
    import ifvm_pkg::*;
(
    // Pending entries
    input wire logic [15:0] pend,
    // Selection
    output logic any,
    output logic [3:0] idx
);
    import ifvm_pkg::*;

    logic [16:0] below;
    logic [3:0] idx_or [17];

    assign below[0] = 1'b0;
    assign idx_or[0] = 4'h0;

    // Chain: an entry wins only when nothing below it is pending
    for (genvar i = 0; i < 16; i++) begin : g_pick
        wire hit = pend[i] & ~below[i];
        assign below[i+1] = below[i] | pend[i];
        assign idx_or[i+1] = idx_or[i] | (hit ? 4'(i) : 4'h0);
    end

    assign any = below[16];
    assign idx = idx_or[16];

endmodule
`default_nettype wire

// ===== ifvm_sticky.sv
// Purpose: Sticky event bits set by a rising flag, cleared by a status read.
// Assumes: Clear is a one-cycle pulse from the bus read.
// Notes: A set in the clear cycle wins so no event is lost.
`timescale 1ns/10ps
`default_nettype none
module ifvm_sticky
    import ifvm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Flags and clear
    input wire ifvm_pkg::ifvm_src_t flag,
    input wire logic clr,
    // Sticky status
    output ifvm_pkg::ifvm_src_t ev_ff
);
    import ifvm_pkg::*;

    ifvm_src_t flag_d_ff;

    // One bit per source: edge detect and hold
    for (genvar i = 1; i <= N_SRC; i++) begin : g_bit
        wire rise = flag[i] & ~flag_d_ff[i];
        wire nxt_ev = rise | (ev_ff[i] & ~clr);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ev_ff[i] <= 1'b0;
                flag_d_ff[i] <= 1'b0;
            end else begin
                ev_ff[i] <= nxt_ev;
                flag_d_ff[i] <= flag[i];
            end
        end
    end

endmodule
`default_nettype wire

// ===== ifvm_top.sv
// Purpose: Pending-flag status registers and vector selection for the core.
// Assumes: Requests and enables are synchronous; core acknowledges the reset vector only.
// Notes: Status registers follow the enabled requests; event bits catch rising edges.
`timescale 1ns/10ps
`default_nettype none
module ifvm_top
    import ifvm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [ifvm_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [ifvm_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt sources
    input wire ifvm_pkg::ifvm_src_t src_req,
    input wire ifvm_pkg::ifvm_src_t src_en,
    input wire logic software_interrupt,
    // Vector port to the core
    input wire logic vec_ack,
    output ifvm_pkg::ifvm_vec_t vec,
    output logic irq
);
    import ifvm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////
    ifvm_src_t flag_ff;
    ifvm_src_t mask_ff;
    ifvm_src_t ev_w;
    ifvm_vec_t vec_ff;
    logic rst_pend_ff;
    logic irq_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    ////////////////////////////////////////////////////////////////////////
    // Flags and events
    ////////////////////////////////////////////////////////////////////////
    // A flag follows its request gated by the source enable
    wire ifvm_src_t nxt_flag = src_req & src_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // Read of the event register clears it; taken on the address handshake
    wire ar_hs = arvalid & arready_ff;
    wire ev_clr = ar_hs & (araddr == A_EVENT);

    ifvm_sticky u_sticky (
        .aclk(aclk),
        .aresetn(aresetn),
        .flag(flag_ff),
        .clr(ev_clr),
        .ev_ff(ev_w)
    );

    // Level interrupt while an unmasked event is held
    wire nxt_irq = |(ev_w & mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // Vector selection
    ////////////////////////////////////////////////////////////////////////
    // Entry 0 is the software interrupt, entries 1..15 the source flags
    wire [15:0] pend_w = {flag_ff, software_interrupt};
    wire pick_any;
    wire [3:0] pick_idx;

    ifvm_prio_enc u_enc (
        .pend(pend_w),
        .any(pick_any),
        .idx(pick_idx)
    );

    // Reset vector outranks everything until the core takes it
    wire rst_taken = vec_ack & vec_ff.rst;
    wire nxt_rst_pend = rst_pend_ff & ~rst_taken;
    wire [15:0] pick_addr = VEC_TAB[pick_idx];
    wire ifvm_vec_t nxt_vec = nxt_rst_pend ? ifvm_vec_t'{1'b1, 1'b1, 4'h0, VEC_RESET} :
        ifvm_vec_t'{pick_any, 1'b0, pick_idx, pick_any ? pick_addr : 16'h0000};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pend_ff <= 1'b1;
            vec_ff <= '{1'b1, 1'b1, 4'h0, VEC_RESET};
            irq_ff <= 1'b0;
        end else begin
            rst_pend_ff <= nxt_rst_pend;
            vec_ff <= nxt_vec;
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    ////////////////////////////////////////////////////////////////////////
    // Status bytes; writes never reach them, so they stay read only
    wire [7:0] low_byte = {flag_ff[6:1], 2'b00};
    wire [7:0] mid_byte = flag_ff[14:7];
    wire [7:0] high_byte = {7'h00, flag_ff[15]};
    wire hit_low = (araddr == A_LOW);
    wire hit_mid = (araddr == A_MID);
    wire hit_high = (araddr == A_HIGH);
    wire hit_ev = (araddr == A_EVENT);
    wire hit_mask = (araddr == A_MASK);
    wire hit_vec = (araddr == A_VECTOR);
    wire rd_mapped = hit_low | hit_mid | hit_high | hit_ev | hit_mask | hit_vec;
    wire [31:0] rd_mux =
        hit_low ? {24'h0000_00, low_byte} :
        hit_mid ? {24'h0000_00, mid_byte} :
        hit_high ? {24'h0000_00, high_byte} :
        hit_ev ? {16'h0000, ev_w, 1'b0} :
        hit_mask ? {16'h0000, mask_ff, 1'b0} :
        hit_vec ? {10'h000, vec_ff} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    ////////////////////////////////////////////////////////////////////////
    // One read in flight: address refused while the answer waits
    wire r_hs = rvalid_ff & rready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (r_hs) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel
    ////////////////////////////////////////////////////////////////////////
    // Address and data are taken in either order, then answered together
    wire aw_hs = awvalid & awready_ff;
    wire w_hs = wvalid & wready_ff;
    wire b_hs = bvalid_ff & bready;
    wire wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
    wire wr_mask = (awaddr_ff == A_MASK);
    wire wr_ro = (awaddr_ff == A_LOW) | (awaddr_ff == A_MID) | (awaddr_ff == A_HIGH) |
        (awaddr_ff == A_EVENT) | (awaddr_ff == A_VECTOR);
    wire [1:0] nxt_bresp = (wr_mask | wr_ro) ? RESP_OKAY : RESP_SLVERR;
    wire [15:0] mask_wr = {wstrb_ff[1] ? wdata_ff[15:8] : mask_ff[15:8],
                           wstrb_ff[0] ? wdata_ff[7:0] : {mask_ff[7:1], 1'b0}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            awaddr_ff <= '0;
        end else if (aw_hs) begin
            awready_ff <= 1'b0;
            awaddr_ff <= awaddr;
        end else if (b_hs) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (w_hs) begin
            wready_ff <= 1'b0;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
        end else if (b_hs) begin
            wready_ff <= 1'b1;
        end
    end

    // Response and the only writable register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            mask_ff <= MASK_RST;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= nxt_bresp;
            if (wr_mask) begin
                mask_ff <= mask_wr[15:1];
            end
        end else if (b_hs) begin
            bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign vec = vec_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////
    // Helpers: source of the offered vector and the entries below it
    wire src_vec = vec_ff.valid & ~vec_ff.rst;
    wire [15:0] below_mask = ~(16'hFFFF << vec_ff.src);

    sequence s_rd(logic [ADDR_W-1:0] a);
        arvalid && arready_ff && araddr == a;
    endsequence

    property p_low_rd;
        @(posedge aclk) disable iff (!aresetn)
        s_rd(A_LOW) |=> rvalid_ff && rdata_ff == {24'h0000_00, $past(low_byte)}
            && rdata_ff[1:0] == 2'b00;
    endproperty
    a_low_rd: assert property (p_low_rd) else $error("low status read wrong");

    property p_mid_rd;
        @(posedge aclk) disable iff (!aresetn)
        s_rd(A_MID) |=> rdata_ff[7:0] == $past(mid_byte) && rdata_ff[31:8] == 24'h0000_00;
    endproperty
    a_mid_rd: assert property (p_mid_rd) else $error("mid status read wrong");

    property p_high_rd;
        @(posedge aclk) disable iff (!aresetn)
        s_rd(A_HIGH) |=> rdata_ff[31:1] == 31'h0000_0000 && rdata_ff[0] == $past(high_byte[0]);
    endproperty
    a_high_rd: assert property (p_high_rd) else $error("high status read wrong");

    property p_timer_vec;
        @(posedge aclk) disable iff (!aresetn)
        src_vec |-> (vec_ff.src != 4'd7 || vec_ff.addr == 16'hFFEE)
            && (vec_ff.src != 4'd6 || vec_ff.addr == 16'hFFF0)
            && (vec_ff.src != 4'd5 || vec_ff.addr == 16'hFFF2);
    endproperty
    a_timer_vec: assert property (p_timer_vec) else $error("timer vector wrong");

    property p_serial_vec;
        @(posedge aclk) disable iff (!aresetn)
        src_vec |-> (vec_ff.src != 4'd13 || vec_ff.addr == 16'hFFE2)
            && (vec_ff.src != 4'd12 || vec_ff.addr == 16'hFFE4);
    endproperty
    a_serial_vec: assert property (p_serial_vec) else $error("serial vector wrong");

    property p_usb_vec;
        @(posedge aclk) disable iff (!aresetn)
        src_vec |-> (vec_ff.src != 4'd2 || vec_ff.addr == 16'hFFF8)
            && (vec_ff.src != 4'd1 || vec_ff.addr == 16'hFFFA);
    endproperty
    a_usb_vec: assert property (p_usb_vec) else $error("usb vector wrong");

    property p_ps2_vec;
        @(posedge aclk) disable iff (!aresetn)
        src_vec && vec_ff.src >= 4'd8 && vec_ff.src <= 4'd11 |->
            vec_ff.addr == 16'hFFFC - {11'h000, vec_ff.src, 1'b0}
            && (vec_ff.src != 4'd8 || vec_ff.addr == 16'hFFEC);
    endproperty
    a_ps2_vec: assert property (p_ps2_vec) else $error("ps2 or reserved vector wrong");

    property p_other_vec;
        @(posedge aclk) disable iff (!aresetn)
        src_vec |-> (vec_ff.src != 4'd15 || vec_ff.addr == 16'hFFDE)
            && (vec_ff.src != 4'd14 || vec_ff.addr == 16'hFFE0)
            && (vec_ff.src != 4'd4 || vec_ff.addr == 16'hFFF4)
            && (vec_ff.src != 4'd3 || vec_ff.addr == 16'hFFF6);
    endproperty
    a_other_vec: assert property (p_other_vec) else $error("misc vector wrong");

    sequence s_pick;
        ##1 src_vec;
    endsequence

    property p_prio;
        @(posedge aclk) disable iff (!aresetn)
        !rst_pend_ff ##0 s_pick |-> ($past(pend_w) & below_mask) == 16'h0000
            && $past(pend_w) != 16'h0000;
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority vector chosen");

    property p_rst_top;
        @(posedge aclk) disable iff (!aresetn)
        rst_pend_ff && !vec_ack |=> vec_ff.rst && vec_ff.addr == 16'hFFFE;
    endproperty
    a_rst_top: assert property (p_rst_top) else $error("reset vector not offered");

    property p_flag;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> flag_ff == ($past(src_req) & $past(src_en));
    endproperty
    a_flag: assert property (p_flag) else $error("flag does not follow request");

endmodule
`default_nettype wire

// ===== ifvm_core_model.sv
// Purpose: Behavioural core that takes vectors and acknowledges the reset vector.
// Assumes: Acknowledge is a one-cycle pulse; the bench sets how long the core waits.
// Notes: Other vectors need no acknowledge, so they are only observed by the bench.
`timescale 1ns/10ps
`default_nettype none
module ifvm_core_model
    import ifvm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Vector port
    input wire ifvm_pkg::ifvm_vec_t vec,
    output logic vec_ack,
    // Bench control
    input wire logic [7:0] ack_delay
);
    ////////////////////////////////////////////////////////////
    logic [7:0] wait_ff;
    logic [7:0] nxt_wait;
    logic nxt_ack;

    // Count while the reset vector is offered; a slow core simply waits longer
    assign nxt_wait = (vec.valid && vec.rst && !vec_ack) ? wait_ff + 8'h01 : 8'h00;
    assign nxt_ack = vec.valid && vec.rst && !vec_ack && (wait_ff >= ack_delay);

    // Ack drops after one cycle so the same offer is never taken twice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_ff <= 8'h00;
            vec_ack <= 1'b0;
        end else begin
            wait_ff <= nxt_wait;
            vec_ack <= nxt_ack;
        end
    end
endmodule
`default_nettype wire

// ===== tb_interrupt_flag_vector_map.sv
// Purpose: Self-checking bench for the interrupt flag and vector map block.
// Assumes: 20 MHz clock, synchronous active-low reset held ten cycles.
// Notes: Every wait is bounded; a wait that runs out counts as a mismatch.
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_flag_vector_map;
    import ifvm_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, software_interrupt;
    logic awready, wready, bvalid, arready, rvalid, irq, vec_ack;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] ack_delay;
    logic [15:0] hot;
    ifvm_src_t src_req, src_en;
    ifvm_vec_t vec;
    int mismatches, compares, w;
    ifvm_src_t pr_req [4] = '{15'h7FFF, 15'h6000, 15'h0090, 15'h7FFF};
    logic [3:0] pr_sw = 4'b1000;
    logic [15:0] pr_adr [4] = '{16'hFFFA, 16'hFFE0, 16'hFFF2, 16'hFFFC};

    ////////////////////////////////////////////////////////////
    // Clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    ifvm_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .src_req(src_req), .src_en(src_en),
        .software_interrupt(software_interrupt), .vec_ack(vec_ack), .vec(vec), .irq(irq));

    ifvm_core_model core (.aclk(aclk), .aresetn(aresetn), .vec(vec), .vec_ack(vec_ack),
        .ack_delay(ack_delay));

    ////////////////////////////////////////////////////////////
    // Verdict in one place, reached by the main sequence or by a timeout
    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic timeout(input string nm);
        mismatches++;
        $display("[ERR] %s expected handshake seen none", nm);
        end_sim();
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // Address and data offered together; bready held until the response
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n >= 50) timeout("write");
    endtask

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n >= 50) timeout("read");
    endtask

    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(nm, e, rd);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF; awprot = 3'h0;
        arprot = 3'h0; src_req = '0; src_en = '0; software_interrupt = 1'b0;
        ack_delay = 8'h14; mismatches = 0; compares = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        ticks(1);
        chk("reset_vec", {10'h0, 1'b1, 1'b1, 4'h0, VEC_RESET}, 32'(vec));
        for (w = 0; w < 60 && vec.rst !== 1'b0; w++) ticks(1);
        if (w >= 60) timeout("reset_ack");
        chk("idle_vec", 32'h0000_0000, 32'(vec));
        rd_chk("pending_flags_low", A_LOW, 32'h0000_0000);
        rd_chk("pending_flags_mid", A_MID, 32'h0000_0000);
        rd_chk("pending_flags_high", A_HIGH, 32'h0000_0000);
        // Each source alone: its status bit and its vector pair
        src_en <= '1;
        for (int n = 1; n <= 15; n++) begin
            hot = 16'h0001 << n;
            src_req <= hot[15:1];
            ticks(3);
            chk("vec", {10'h0, 2'b10, 4'(n), 16'hFFFC - 16'(2 * n)}, 32'(vec));
            rd_chk("pending_flags_low", A_LOW, {24'h0, hot[6:1], 2'b00});
            rd_chk("pending_flags_mid", A_MID, {24'h0, hot[14:7]});
            rd_chk("pending_flags_high", A_HIGH, {31'h0, hot[15]});
        end
        // Several pending at once: the highest vector address wins
        for (int i = 0; i < 4; i++) begin
            src_req <= pr_req[i];
            software_interrupt <= pr_sw[i];
            ticks(3);
            chk("prio_vec", {15'h0, 1'b1, pr_adr[i]}, {15'h0, vec.valid, vec.addr});
        end
        // Read-only status ignores writes; unmapped places answer with an error
        axi_wr(A_LOW, 32'h0000_00FF);
        chk("ro_bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
        rd_chk("pending_flags_low", A_LOW, 32'h0000_00FC);
        axi_wr(A_HIGH + 18'h4, 32'h0000_0001);
        chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_rd(A_HIGH + 18'h4);
        chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped_rdata", 32'h0000_0000, rd);
        // Disabled requests show nothing; removed requests clear the flag
        software_interrupt <= 1'b0;
        src_en <= '0;
        ticks(3);
        chk("masked_vec", 32'h0000_0000, 32'(vec));
        rd_chk("pending_flags_mid", A_MID, 32'h0000_0000);
        src_en <= '1;
        src_req <= '0;
        ticks(3);
        rd_chk("pending_flags_mid", A_MID, 32'h0000_0000);
        // Events, mask and interrupt line
        axi_rd(A_EVENT);
        axi_wr(A_MASK, 32'h0000_0008);
        rd_chk("mask", A_MASK, 32'h0000_0008);
        src_req <= 15'h000C;
        ticks(4);
        chk("irq_set", 32'h1, {31'h0, irq});
        rd_chk("event", A_EVENT, 32'h0000_0018);
        rd_chk("event_clr", A_EVENT, 32'h0000_0000);
        ticks(2);
        chk("irq_clr", 32'h0, {31'h0, irq});
        src_req <= 15'h0000;
        ticks(2);
        src_req <= 15'h0008;
        ticks(4);
        chk("irq_masked", 32'h0, {31'h0, irq});
        axi_wr(A_MASK, 32'h0000_0010);
        ticks(2);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        rd_chk("event", A_EVENT, 32'h0000_0010);
        ticks(2);
        chk("irq_end", 32'h0, {31'h0, irq});
        end_sim();
    end
endmodule
`default_nettype wire
